// [pps_pkg.sv]
// Function
// - page zero shows selected port's status
// - unimplemented port reads all zeros
// - pair A field reports arbitration line state
// - pair B field uses same codes
// - role bit one for child, disconnected too
// - connected set after 341 ms stable
// - connected cleared when connect detect drops, and by reset
// - bias set after 52 us stable
// - writing one disables port, reset enables
// - peer speed field codes S100/S200/S400
// - peer speed never reported above 010b
// - enabled events set flag, notify link
// - notification enable is reset-cleared read/write
// - suspend/resume fault sets fault flag
// - resume fault: no bias while resuming
// - suspend fault: bias while suspending
// - write one clears fault, reset clears
// - page selector picks page, reset clears
// - event flag on bias (unless port disabled)/con/dis/fault change
//
// package for the port status page: constants, field layout, carriers.
// assumes a single 25 MHz system clock shared with the apb master.
package pps_pkg;

	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ       = 25000000;                   // system clock rate
	localparam int unsigned CON_DEB_MS   = 341;                        // connect debounce, ms
	localparam int unsigned CON_DEB_CYC  = CON_DEB_MS * (CLK_HZ / 1000);
	localparam int unsigned BIAS_DEB_US  = 52;                         // bias debounce, us
	localparam int unsigned BIAS_DEB_CYC = BIAS_DEB_US * (CLK_HZ / 1000000);
	localparam int          CON_CNT_W    = 24;                         // fits 8,525,000
	localparam int          BIAS_CNT_W   = 11;                         // fits 1,300

	// ==========================================================
	// register indices, byte address is index times four
	localparam logic [5:0] IDX_EVENT  = 6'h06; // port event flag
	localparam logic [5:0] IDX_SELECT = 6'h07; // page and port selectors
	localparam logic [5:0] IDX_LINE   = 6'h08; // line and link state
	localparam logic [5:0] IDX_PEER   = 6'h09; // peer speed and event control
	localparam logic [5:0] IDX_LAST   = 6'h0f; // last address of the page window

	// ==========================================================
	// field positions
	localparam int SEL_PAGE_LSB = 0;  // page selector [2:0]
	localparam int SEL_PORT_LSB = 4;  // port selector [7:4]
	localparam int LN_PA_LSB    = 6;  // pair a state [7:6]
	localparam int LN_PB_LSB    = 4;  // pair b state [5:4]
	localparam int LN_DOWN_BIT  = 3;
	localparam int LN_CON_BIT   = 2;
	localparam int LN_BIAS_BIT  = 1;
	localparam int LN_DIS_BIT   = 0;
	localparam int PR_SPD_LSB   = 5;  // peer speed [7:5]
	localparam int PR_INTEN_BIT = 4;
	localparam int PR_FAULT_BIT = 3;
	localparam int EV_FLAG_BIT  = 0;

	// ==========================================================
	// codes and sizes
	localparam logic [2:0] PAGE_PORT_STATUS = 3'h0;
	localparam logic [3:0] NUM_PORTS        = 4'h1; // only port 0 exists
	localparam logic [2:0] SPD_S100         = 3'h0;
	localparam logic [2:0] SPD_S200         = 3'h1;
	localparam logic [2:0] SPD_S400         = 3'h2;

	// raw cable pins, asynchronous to pclk
	typedef struct packed {
		logic [1:0] tpa;     // pair a arbitration code
		logic [1:0] tpb;     // pair b arbitration code
		logic       conn;    // raw connect detect
		logic       bias;    // raw incoming bias detect
	} pps_pins_t;

	// port state from the phy core, same clock
	typedef struct packed {
		logic       is_parent;   // port is the parent after tree-id
		logic       suspended;   // port suspended
		logic [2:0] peer_speed;  // speed heard from peer
		logic       resume_end;  // pulse: resume bias check window over
		logic       suspend_end; // pulse: suspend bias check window over
	} pps_core_t;

	// whole module state
	typedef struct packed {
		pps_pins_t              s1, s2, s3;   // three stage synchroniser
		pps_pins_t              stb;          // agreed pin levels
		logic [CON_CNT_W-1:0]   con_cnt;
		logic [BIAS_CNT_W-1:0]  bias_cnt;
		logic                   con, bias, dis, int_en, fault, event_flag;
		logic [2:0]             peer_speed;
		logic [2:0]             page;
		logic [3:0]             port;
		logic [31:0]            rdata;
		logic                   slverr;
	} pps_state_t;

endpackage

// [pps_port_status.sv]
// port status page register bank for one cable port, apb slave.
// assumes pins arrive asynchronously and core signals on pclk.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module pps_port_status
	import pps_pkg::*;
#(
	parameter int unsigned CON_DEBOUNCE_CYC = CON_DEB_CYC // shorten in simulation
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire pps_pins_t   pins,
	input  wire pps_core_t   core,
	output logic             port_disabled,
	output logic             port_fault,
	output logic             link_notify
);

	// ==========================================================
	// limits
	localparam logic [CON_CNT_W-1:0]  CON_LIM  = CON_CNT_W'(CON_DEBOUNCE_CYC - 1);
	localparam logic [BIAS_CNT_W-1:0] BIAS_LIM = BIAS_CNT_W'(BIAS_DEB_CYC - 1);

	pps_state_t st_r;    // registered state
	pps_state_t st_nxt;  // next state

	logic [5:0] idx;        // word index from address
	logic       page0;      // port status page visible
	logic       wr_acc;     // write taking effect this edge
	logic       mapped;     // index decodes
	logic [7:0] rd_byte;    // read byte before padding
	logic       res_fault;  // resume fault detected
	logic       sus_fault;  // suspend fault detected
	logic [3:0] watch_old;  // bias, con, dis, fault now
	logic [3:0] watch_new;  // same after this edge
	logic       downstream; // role bit value

	// ==========================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		idx    = paddr[7:2];
		// unimplemented ports hide the whole page
		page0  = (st_r.page == PAGE_PORT_STATUS) && (st_r.port < NUM_PORTS);
		wr_acc = psel & penable & pwrite & pstrb[0];
		mapped = (idx >= IDX_EVENT) && (idx <= IDX_LAST);

		// pins: three flops, a change counts when stages two and three agree
		st_nxt.s1  = pins;
		st_nxt.s2  = st_r.s1;
		st_nxt.s3  = st_r.s2;
		st_nxt.stb = (st_r.s2 & st_r.s3) | (st_r.stb & (st_r.s2 | st_r.s3));

		// connect debounce: set only after a full stable interval
		if (!st_r.stb.conn) begin
			st_nxt.con_cnt = '0;
			st_nxt.con     = 1'b0;
		end else if (st_r.con_cnt == CON_LIM) begin
			st_nxt.con = 1'b1;
		end else begin
			st_nxt.con_cnt = st_r.con_cnt + 1'b1;
		end

		// bias debounce, same scheme with the short interval
		if (!st_r.stb.bias) begin
			st_nxt.bias_cnt = '0;
			st_nxt.bias     = 1'b0;
		end else if (st_r.bias_cnt == BIAS_LIM) begin
			st_nxt.bias = 1'b1;
		end else begin
			st_nxt.bias_cnt = st_r.bias_cnt + 1'b1;
		end

		// peer speed: nothing above s400 can be detected, so clamp
		if (core.peer_speed > SPD_S400) begin
			st_nxt.peer_speed = SPD_S400;
		end else begin
			st_nxt.peer_speed = core.peer_speed;
		end

		// fault checks at the end of each bias check window
		res_fault = core.resume_end & ~st_r.bias;
		sus_fault = core.suspend_end & st_r.bias;

		// ------------------------------------------------------
		// register writes
		if (wr_acc && idx == IDX_SELECT) begin
			st_nxt.page = pwdata[SEL_PAGE_LSB +: 3];
			st_nxt.port = pwdata[SEL_PORT_LSB +: 4];
		end
		if (wr_acc && page0 && idx == IDX_LINE) begin
			st_nxt.dis = pwdata[LN_DIS_BIT];
		end
		if (wr_acc && page0 && idx == IDX_PEER) begin
			st_nxt.int_en = pwdata[PR_INTEN_BIT];
			if (pwdata[PR_FAULT_BIT]) begin
				st_nxt.fault = 1'b0;
			end
		end
		// set wins over a clear in the same cycle
		if (res_fault || sus_fault) begin
			st_nxt.fault = 1'b1;
		end

		// event flag: watched bits changing while enabled
		watch_old = {st_r.bias, st_r.con, st_r.dis, st_r.fault};
		watch_new = {st_nxt.bias, st_nxt.con, st_nxt.dis, st_nxt.fault};
		if (st_r.dis) begin
			// bias changes are ignored on a disabled port
			watch_new[3] = watch_old[3];
		end
		if (wr_acc && idx == IDX_EVENT && pwdata[EV_FLAG_BIT]) begin
			st_nxt.event_flag = 1'b0;
		end
		if (st_r.int_en && (watch_new != watch_old)) begin
			st_nxt.event_flag = 1'b1;
		end

		// ------------------------------------------------------
		// role bit: anything not an active parent reads as child
		downstream = ~(core.is_parent & st_r.con & ~st_r.dis & ~core.suspended);

		// read mux, unlisted bits and addresses stay zero
		rd_byte = 8'h00;
		case (idx)
			IDX_EVENT: begin
				rd_byte[EV_FLAG_BIT] = st_r.event_flag;
			end
			IDX_SELECT: begin
				rd_byte[SEL_PAGE_LSB +: 3] = st_r.page;
				rd_byte[SEL_PORT_LSB +: 4] = st_r.port;
			end
			IDX_LINE: begin
				if (page0) begin
					rd_byte[LN_PA_LSB +: 2] = st_r.stb.tpa;
					rd_byte[LN_PB_LSB +: 2] = st_r.stb.tpb;
					rd_byte[LN_DOWN_BIT]    = downstream;
					rd_byte[LN_CON_BIT]     = st_r.con;
					rd_byte[LN_BIAS_BIT]    = st_r.bias;
					rd_byte[LN_DIS_BIT]     = st_r.dis;
				end
			end
			IDX_PEER: begin
				if (page0) begin
					rd_byte[PR_SPD_LSB +: 3] = st_r.peer_speed;
					rd_byte[PR_INTEN_BIT]    = st_r.int_en;
					rd_byte[PR_FAULT_BIT]    = st_r.fault;
				end
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase

		// answer prepared in the setup cycle so the access needs no wait
		if (psel && !penable) begin
			st_nxt.rdata  = {24'h000000, rd_byte};
			st_nxt.slverr = ~mapped;
		end
	end

	// ==========================================================
	// state register, constant under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign pready        = 1'b1;        // every access completes at once
	assign prdata        = st_r.rdata;
	assign pslverr       = st_r.slverr;
	assign port_disabled = st_r.dis;
	assign port_fault    = st_r.fault;
	assign link_notify   = st_r.event_flag;

endmodule

`default_nettype wire

// [pps_peer.sv]
// cable peer and phy core stand-in driving the port inputs.
// assumes callers change levels just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module pps_peer
	import pps_pkg::*;
(
	input  wire logic     pclk,
	output var pps_pins_t pins,
	output var pps_core_t core
);
	// ==========
	// idle: unplugged, no bias, no window pulses
	initial begin
		pins = '0;
		core = '0;
	end
	// one-cycle end of a bias check window
	task automatic pulse(input logic resume);
		@(posedge pclk);
		core.resume_end  <= resume;
		core.suspend_end <= !resume;
		@(posedge pclk);
		core.resume_end  <= 1'b0;
		core.suspend_end <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [pps_port_status_monitor.sv]
// checker for the port status page, bound to the top module.
// assumes selectors at word 7 and only port 0 present.
`timescale 1ns/10ps
`default_nettype none
module pps_port_status_chk
	import pps_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire pps_pins_t   pins,
	input wire pps_core_t   core,
	input wire logic        port_disabled,
	input wire logic        port_fault,
	input wire logic        link_notify
);
	// ==========
	// shadow selectors so page-zero accesses are known
	logic [6:0] sel_r;
	logic       en_r;
	logic       wr, rd, p0, bad, hit9, pend;
	assign wr   = psel && penable && pwrite && pstrb[0];
	assign rd   = psel && penable && !pwrite;
	assign p0   = sel_r == 7'h00;
	assign bad  = paddr[7:2] < IDX_EVENT || paddr[7:2] > IDX_LAST;
	assign hit9 = wr && p0 && paddr[7:2] == IDX_PEER;
	assign pend = core.resume_end || core.suspend_end;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_r <= 7'h00;
			en_r  <= 1'b0;
		end else if (wr && paddr[7:2] == IDX_SELECT) begin
			sel_r <= {pwdata[7:4], pwdata[2:0]};
		end else if (hit9) begin
			en_r <= pwdata[4];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_err_map: assert property (psel && penable |-> pslverr == bad)
		else $error("error flag wrong");
	a_other_page: assert property (rd && !p0 && paddr[7:2] >= IDX_LINE && !bad |-> prdata == 0)
		else $error("other page not zero");
	a_spd_max: assert property (rd && p0 && paddr[7:2] == IDX_PEER |-> prdata[7:5] <= 3'h2)
		else $error("speed above 010");
	a_dis_write: assert property (wr && p0 && paddr[7:2] == IDX_LINE |=> port_disabled == $past(pwdata[0]))
		else $error("disable not written");
	a_fault_cause: assert property ($rose(port_fault) |-> $past(core.resume_end) || $past(core.suspend_end))
		else $error("fault without window end");
	a_fault_clr: assert property (port_fault && hit9 && pwdata[3] && !pend |=> !port_fault)
		else $error("fault not cleared");
	a_notify_fault: assert property ($rose(port_fault) && en_r |-> ##[0:1] link_notify)
		else $error("fault event not flagged");
	cover property (hit9 && pwdata[3]);
	cover property ($rose(link_notify));
	cover property (psel && penable && bad);
endmodule
bind pps_port_status pps_port_status_chk pps_port_status_chk_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
	.prdata, .pslverr, .pins, .core, .port_disabled, .port_fault, .link_notify
);
`default_nettype wire

// [pps_port_status_bench.sv]
// self-checking bench for the port status page with a cable peer.
// assumes a 20-cycle connect debounce to keep the run short.
`timescale 1ns/10ps
`default_nettype none
module pps_port_status_bench
	import pps_pkg::*;
;
	// ==========
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        port_disabled, port_fault, link_notify;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	pps_pins_t   pins;
	pps_core_t   core;
	logic [32:0] exp_q[$];  // pending reads: error bit, data
	int          n_fail, n_checks, seed;
	pps_port_status #(.CON_DEBOUNCE_CYC(20)) pps_port_status_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
		.prdata, .pslverr, .pins, .core, .port_disabled, .port_fault, .link_notify
	);
	pps_peer pps_peer_inst (.pclk, .pins, .core);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// apb transfer, request held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic chk(input logic [32:0] e, input logic [32:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	// watcher: oldest note against each read answer
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite)
			chk(exp_q.pop_front(), {pslverr, prdata});
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		n_fail = 0;
		n_checks = 0;
		seed = $urandom(12411);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h18, 33'h0);
		rd(8'h1c, 33'h0);
		rd(8'h20, 33'h8);
		rd(8'h24, 33'h0);
		$display("reset values done");
		for (int c = 0; c < 4; c++) begin
			pps_peer_inst.pins.tpa <= 2'(c);
			pps_peer_inst.pins.tpb <= 2'(3 - c);
			repeat (6) @(posedge pclk);
			rd(8'h20, 33'({2'(c), 2'(3 - c), 4'h8}));
		end
		xfer(1'b1, 8'h24, 32'h10);
		// no bus reset here, so speed and role stay trusted
		for (int s = 0; s < 8; s++) begin
			pps_peer_inst.core.peer_speed <= 3'(s);
			repeat (3) @(posedge pclk);
			rd(8'h24, 33'({(s > 2) ? 3'h2 : 3'(s), 5'h10}));
		end
		$display("line and speed done");
		pps_peer_inst.core.is_parent <= 1'b1;
		pps_peer_inst.pins.conn <= 1'b1;
		pps_peer_inst.pins.bias <= 1'b1;
		repeat (12) @(posedge pclk);
		rd(8'h20, 33'hc8);
		repeat (30) @(posedge pclk);
		rd(8'h20, 33'hc4);
		chk(33'h1, 33'(link_notify));
		// a suspended parent port must read as a child
		pps_peer_inst.core.suspended <= 1'b1;
		@(posedge pclk);
		rd(8'h20, 33'hcc);
		pps_peer_inst.core.suspended <= 1'b0;
		repeat (1400) @(posedge pclk);
		rd(8'h20, 33'hc6);
		xfer(1'b1, 8'h18, 32'h1);
		rd(8'h18, 33'h0);
		xfer(1'b1, 8'h20, 32'h1);
		pstrb <= 4'h0;
		xfer(1'b1, 8'h20, 32'h0);
		pstrb <= 4'hf;
		rd(8'h20, 33'hcf);
		rd(8'h18, 33'h1);
		$display("connect and disable done");
		pps_peer_inst.pulse(1'b1);
		rd(8'h24, 33'h50);
		pps_peer_inst.pulse(1'b0);
		rd(8'h24, 33'h58);
		xfer(1'b1, 8'h24, 32'h18);
		rd(8'h24, 33'h50);
		pps_peer_inst.pins.bias <= 1'b0;
		repeat (8) @(posedge pclk);
		pps_peer_inst.pulse(1'b1);
		rd(8'h24, 33'h58);
		chk(33'h1, 33'(port_fault));
		$display("fault done");
		rd(8'h00, 33'h1_0000_0000);
		rd(8'h40, 33'h1_0000_0000);
		xfer(1'b1, 8'h28, $urandom);
		rd(8'h28, 33'h0);
		xfer(1'b1, 8'h1c, 32'h10);
		rd(8'h20, 33'h0);
		xfer(1'b1, 8'h1c, 32'h1);
		rd(8'h1c, 33'h1);
		rd(8'h24, 33'h0);
		xfer(1'b1, 8'h1c, 32'h0);
		rd(8'h20, 33'hcd);
		$display("map done");
		test_done();
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (6000) @(posedge pclk);
		n_fail++;
		test_done();
	end
	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
endmodule
`default_nettype wire
